// file: rtl/aecd_pkg.sv
// constants and types shared by the accelerometer event and tap logic
package aecd_pkg;
    // register offsets on the register port
    localparam logic [7:0] AECD_OFF_MOTION_SRC = 8'h31;
    localparam logic [7:0] AECD_OFF_MOTION_THS = 8'h32;
    localparam logic [7:0] AECD_OFF_MOTION_DUR = 8'h33;
    localparam logic [7:0] AECD_OFF_TAP_CFG = 8'h38;
    localparam logic [7:0] AECD_OFF_TAP_SRC = 8'h39;
    localparam logic [7:0] AECD_OFF_TAP_THS = 8'h3A;
    localparam logic [7:0] AECD_OFF_TAP_LEN = 8'h3B;
    localparam logic [7:0] AECD_OFF_TAP_DEAD = 8'h3C;
    localparam logic [7:0] AECD_OFF_TAP_WIN = 8'h3D;
    localparam logic [7:0] AECD_OFF_WAKE_THS = 8'h3E;
    localparam logic [7:0] AECD_OFF_WAKE_DUR = 8'h3F;
    // values after reset
    localparam logic [6:0] AECD_RST_7 = 7'h00;
    localparam logic [7:0] AECD_RST_8 = 8'h00;
    localparam logic [5:0] AECD_RST_6 = 6'h00;
    // motion source layout: bit 6 active, bits 5..0 zh zl yh yl xh xl
    localparam int AECD_MSRC_ACTIVE = 6;
    // tap source layout
    localparam int AECD_TSRC_ACTIVE = 6;
    localparam int AECD_TSRC_DOUBLE = 5;
    localparam int AECD_TSRC_SINGLE = 4;
    localparam int AECD_TSRC_SIGN = 3;
    // wake duration: (value + 1) * 8 samples
    localparam int AECD_WAKE_STEP = 8;
    localparam int AECD_WAKE_LSB_SHIFT = 4;
    // one accelerometer sample set
    typedef struct packed {
        logic signed [15:0] z;
        logic signed [15:0] y;
        logic signed [15:0] x;
    } aecd_accel_t;
    // interrupt 1 combination modes {and, orientation}
    typedef enum logic [1:0] {
        AECD_MODE_OR = 2'h0,
        AECD_MODE_MOVE = 2'h1,
        AECD_MODE_AND = 2'h2,
        AECD_MODE_POS = 2'h3
    } aecd_mode_t;
endpackage

// file: rtl/aecd_tap_axis.sv
// single axis tap excursion detector
`timescale 1ns/100ps
`default_nettype none
module aecd_tap_axis (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sample_tick,
    input wire logic signed [15:0] sample,
    input wire logic [6:0] tap_limit_value,
    input wire logic [7:0] tap_length_value,
    output logic tap_pulse,
    output logic tap_neg
);
    import aecd_pkg::*;
    logic [7:0] hi_byte;
    logic [7:0] mag;
    logic over;
    logic in_exc_reg;
    logic [7:0] len_reg;

    // magnitude of the upper byte against the threshold
    assign hi_byte = sample[15:8];
    assign mag = hi_byte[7] ? 8'(-hi_byte) : hi_byte;
    assign over = mag > {1'b0, tap_limit_value};

    // track excursion length and report short ones when they end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            in_exc_reg <= 1'b0;
            len_reg <= 8'h00;
            tap_pulse <= 1'b0;
            tap_neg <= 1'b0;
        end else begin
            tap_pulse <= 1'b0;
            if (sample_tick) begin
                if (over && !in_exc_reg) begin
                    in_exc_reg <= 1'b1;
                    len_reg <= 8'h00;
                    tap_neg <= sample[15];
                end else if (over) begin
                    if (len_reg != 8'hFF) begin
                        len_reg <= len_reg + 8'h01;
                    end
                end else if (in_exc_reg) begin
                    in_exc_reg <= 1'b0;
                    tap_pulse <= (len_reg <= tap_length_value);
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/aecd_wake.sv
// sleep-to-wake and return-to-sleep activity timer
`timescale 1ns/100ps
`default_nettype none
module aecd_wake (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sample_tick,
    input wire aecd_pkg::aecd_accel_t accel,
    input wire logic [6:0] wake_limit_value,
    input wire logic [7:0] wake_time_value,
    output logic sleeping
);
    import aecd_pkg::*;
    logic [2:0] act;
    logic [11:0] quiet_reg;
    logic [11:0] limit;

    // one threshold step is one 16 mg lsb group of the sample
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_ax
            logic signed [15:0] s;
            logic [15:0] m;
            assign s = accel[16*i +: 16];
            assign m = s[15] ? 16'(-s) : 16'(s);
            assign act[i] = (m >> AECD_WAKE_LSB_SHIFT) >
                {9'h000, wake_limit_value};
        end
    endgenerate

    // (value + 1) * 8 quiet samples send the block to sleep
    assign limit = 12'(({4'h0, wake_time_value} + 12'h001) *
        AECD_WAKE_STEP);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            quiet_reg <= 12'h000;
            sleeping <= 1'b0;
        end else if (sample_tick) begin
            if (|act) begin
                quiet_reg <= 12'h000;
                sleeping <= 1'b0;
            end else if (quiet_reg + 12'h001 >= limit) begin
                sleeping <= 1'b1;
            end else begin
                quiet_reg <= quiet_reg + 12'h001;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/aecd_core.sv
// accelerometer motion event, tap and wake logic with its registers
//
// Contract
// - motion source active flag set by events
// - six per-axis high/low flags, zero at reset
// - source read clears flag, pin, frees latch
// - motion source register ignores writes
// - condition must persist the minimum time
// - per-axis double tap enables
// - per-axis single tap enables
// - tap source active flag set by taps
// - tap source shows double and single kind
// - tap source sign: one means negative
// - per-axis tap flags in tap source
// - tap threshold compared against acceleration
// - tap excursion no longer than limit
// - dead time after first tap
// - wake threshold in 16 mg steps
// - wake duration is (value+1)*8 samples
// - two-bit mode selects event combination
// - per-axis enable gates each motion event
`timescale 1ns/100ps
`default_nettype none
module aecd_core (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sample_tick,
    input wire aecd_pkg::aecd_accel_t accel,
    input wire logic [5:0] axis_irq_en,
    input wire logic combine_and_select,
    input wire logic orientation_select,
    input wire logic latch_sel,
    output logic motion_irq_pin,
    output logic tap_irq_pin,
    output logic sleep_state
);
    import aecd_pkg::*;

    typedef enum {
        TAP_IDLE,
        TAP_DEAD,
        TAP_WIN
    } aecd_tap_state_t;

    logic [6:0] motion_limit_value_reg;
    logic [6:0] motion_min_time_value_reg;
    logic [5:0] tap_cfg_reg;
    logic [6:0] tap_limit_value_reg;
    logic [7:0] tap_length_value_reg;
    logic [7:0] tap_dead_value_reg;
    logic [7:0] tap_window_value_reg;
    logic [6:0] wake_limit_value_reg;
    logic [7:0] wake_time_value_reg;

    logic [5:0] cond;
    logic [5:0] en_cond;
    logic zone_hit;
    logic [6:0] dur_cnt_reg;
    logic filt_reg;
    logic filt_next;
    logic motion_evt;
    logic [5:0] axis_flags_reg;
    logic motion_active_reg;
    logic motion_active_next;
    logic rd_motion;
    logic rd_tap;
    aecd_mode_t mode;

    logic [2:0] tap_pulse;
    logic [2:0] tap_neg;
    logic [2:0] single_en;
    logic [2:0] double_en;
    logic [2:0] tap_hit;
    logic tap_any;
    logic single_evt;
    logic double_evt;
    aecd_tap_state_t tap_state_reg;
    logic [7:0] tap_cnt_reg;
    logic [6:0] tap_src_reg;
    logic tap_active_next;
    logic wake_sleep;

    assign rd_motion = reg_rd && (reg_addr == AECD_OFF_MOTION_SRC);
    assign rd_tap = reg_rd && (reg_addr == AECD_OFF_TAP_SRC);
    assign mode = aecd_mode_t'({combine_and_select, orientation_select});

    // software writable settings; source registers take no writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            motion_limit_value_reg <= AECD_RST_7;
            motion_min_time_value_reg <= AECD_RST_7;
            tap_cfg_reg <= AECD_RST_6;
            tap_limit_value_reg <= AECD_RST_7;
            tap_length_value_reg <= AECD_RST_8;
            tap_dead_value_reg <= AECD_RST_8;
            tap_window_value_reg <= AECD_RST_8;
            wake_limit_value_reg <= AECD_RST_7;
            wake_time_value_reg <= AECD_RST_8;
        end else if (reg_wr) begin
            case (reg_addr)
                AECD_OFF_MOTION_THS: motion_limit_value_reg <= reg_wdata[6:0];
                AECD_OFF_MOTION_DUR: begin
                    motion_min_time_value_reg <= reg_wdata[6:0];
                end
                AECD_OFF_TAP_CFG: tap_cfg_reg <= reg_wdata[5:0];
                AECD_OFF_TAP_THS: tap_limit_value_reg <= reg_wdata[6:0];
                AECD_OFF_TAP_LEN: tap_length_value_reg <= reg_wdata;
                AECD_OFF_TAP_DEAD: tap_dead_value_reg <= reg_wdata;
                AECD_OFF_TAP_WIN: tap_window_value_reg <= reg_wdata;
                AECD_OFF_WAKE_THS: wake_limit_value_reg <= reg_wdata[6:0];
                AECD_OFF_WAKE_DUR: wake_time_value_reg <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // registered read data, unmapped offsets read zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    AECD_OFF_MOTION_SRC: begin
                        reg_rdata <= {1'b0, motion_active_reg, axis_flags_reg};
                    end
                    AECD_OFF_MOTION_THS: begin
                        reg_rdata <= {1'b0, motion_limit_value_reg};
                    end
                    AECD_OFF_MOTION_DUR: begin
                        reg_rdata <= {1'b0, motion_min_time_value_reg};
                    end
                    AECD_OFF_TAP_CFG: reg_rdata <= {2'h0, tap_cfg_reg};
                    AECD_OFF_TAP_SRC: reg_rdata <= {1'b0, tap_src_reg};
                    AECD_OFF_TAP_THS: reg_rdata <= {1'b0, tap_limit_value_reg};
                    AECD_OFF_TAP_LEN: reg_rdata <= tap_length_value_reg;
                    AECD_OFF_TAP_DEAD: reg_rdata <= tap_dead_value_reg;
                    AECD_OFF_TAP_WIN: reg_rdata <= tap_window_value_reg;
                    AECD_OFF_WAKE_THS: begin
                        reg_rdata <= {1'b0, wake_limit_value_reg};
                    end
                    AECD_OFF_WAKE_DUR: reg_rdata <= wake_time_value_reg;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // per-axis high and low comparisons on the upper sample byte
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_motion
            logic signed [7:0] hb;
            logic signed [7:0] lim;
            assign hb = accel[16*i+8 +: 8];
            assign lim = {1'b0, motion_limit_value_reg};
            assign cond[2*i+1] = hb > lim;
            assign cond[2*i] = hb < -lim;
        end
    endgenerate

    assign en_cond = cond & axis_irq_en;

    // combine enabled conditions according to the selected mode
    always_comb begin
        case (mode)
            AECD_MODE_AND: zone_hit = (axis_irq_en != 6'h00) &&
                (en_cond == axis_irq_en);
            AECD_MODE_OR: zone_hit = |en_cond;
            AECD_MODE_MOVE: zone_hit = |en_cond;
            AECD_MODE_POS: zone_hit = |en_cond;
            default: zone_hit = 1'b0;
        endcase
    end

    // condition must persist for the minimum time before recognition
    assign filt_next = zone_hit &&
        (dur_cnt_reg >= motion_min_time_value_reg);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dur_cnt_reg <= 7'h00;
            filt_reg <= 1'b0;
        end else if (sample_tick) begin
            filt_reg <= filt_next;
            if (!zone_hit) begin
                dur_cnt_reg <= 7'h00;
            end else if (dur_cnt_reg < motion_min_time_value_reg) begin
                dur_cnt_reg <= dur_cnt_reg + 7'h01;
            end
        end
    end

    // movement mode fires on entry; other modes while recognised
    assign motion_evt = sample_tick && filt_next &&
        ((mode != AECD_MODE_MOVE) || !filt_reg);

    // active flag: the event wins over a clearing read
    assign motion_active_next = motion_evt ? 1'b1 :
        (rd_motion ? 1'b0 : motion_active_reg);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            motion_active_reg <= 1'b0;
            motion_irq_pin <= 1'b0;
        end else begin
            motion_active_reg <= motion_active_next;
            motion_irq_pin <= motion_active_next;
        end
    end

    // per-axis flags: latched until read, otherwise live per sample
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            axis_flags_reg <= 6'h00;
        end else if (latch_sel) begin
            if (rd_motion) begin
                axis_flags_reg <= motion_evt ? en_cond : 6'h00;
            end else if (motion_evt) begin
                axis_flags_reg <= axis_flags_reg | en_cond;
            end
        end else if (sample_tick) begin
            axis_flags_reg <= en_cond;
        end
    end

    // tap excursion detectors, one per axis
    generate
        for (i = 0; i < 3; i++) begin : g_tap
            aecd_tap_axis u_tap (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .sample_tick(sample_tick),
                .sample(accel[16*i +: 16]),
                .tap_limit_value(tap_limit_value_reg),
                .tap_length_value(tap_length_value_reg),
                .tap_pulse(tap_pulse[i]),
                .tap_neg(tap_neg[i])
            );
            assign single_en[i] = tap_cfg_reg[2*i];
            assign double_en[i] = tap_cfg_reg[2*i+1];
        end
    endgenerate

    assign tap_hit = tap_pulse & (single_en | double_en);
    assign tap_any = |tap_hit;
    assign single_evt = |(tap_pulse & single_en) &&
        (tap_state_reg != TAP_WIN);
    assign double_evt = |(tap_pulse & double_en) &&
        (tap_state_reg == TAP_WIN);

    // first tap, dead time, then second tap window
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tap_state_reg <= TAP_IDLE;
            tap_cnt_reg <= 8'h00;
        end else begin
            case (tap_state_reg)
                TAP_IDLE: begin
                    if (tap_any) begin
                        tap_state_reg <= TAP_DEAD;
                        tap_cnt_reg <= 8'h00;
                    end
                end
                TAP_DEAD: begin
                    if (sample_tick) begin
                        if (tap_cnt_reg >= tap_dead_value_reg) begin
                            tap_state_reg <= TAP_WIN;
                            tap_cnt_reg <= 8'h00;
                        end else begin
                            tap_cnt_reg <= tap_cnt_reg + 8'h01;
                        end
                    end
                end
                TAP_WIN: begin
                    if (double_evt) begin
                        tap_state_reg <= TAP_IDLE;
                    end else if (sample_tick) begin
                        if (tap_cnt_reg >= tap_window_value_reg) begin
                            tap_state_reg <= TAP_IDLE;
                        end else begin
                            tap_cnt_reg <= tap_cnt_reg + 8'h01;
                        end
                    end
                end
                default: tap_state_reg <= TAP_IDLE;
            endcase
        end
    end

    // tap source active flag: a tap wins over a clearing read
    assign tap_active_next = (single_evt || double_evt) ? 1'b1 :
        (rd_tap ? 1'b0 : tap_src_reg[AECD_TSRC_ACTIVE]);

    // tap source: kind, sign and axes of the last reported tap
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tap_src_reg <= 7'h00;
            tap_irq_pin <= 1'b0;
        end else begin
            tap_src_reg[AECD_TSRC_ACTIVE] <= tap_active_next;
            tap_irq_pin <= tap_active_next;
            if (single_evt || double_evt) begin
                tap_src_reg[AECD_TSRC_DOUBLE] <= double_evt;
                tap_src_reg[AECD_TSRC_SINGLE] <= single_evt;
                tap_src_reg[AECD_TSRC_SIGN] <= |(tap_neg & tap_hit);
                tap_src_reg[2:0] <= tap_hit;
            end
        end
    end

    // activity timer for sleep-to-wake decisions
    aecd_wake u_wake (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample_tick(sample_tick),
        .accel(accel),
        .wake_limit_value(wake_limit_value_reg),
        .wake_time_value(wake_time_value_reg),
        .sleeping(wake_sleep)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sleep_state <= 1'b0;
        end else begin
            sleep_state <= wake_sleep;
        end
    end
endmodule
`default_nettype wire

// file: verif/aecd_core_sva.sv
// assertion checker for the accelerometer event and tap block
`timescale 1ns/100ps
`default_nettype none
module aecd_core_sva (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic sample_tick,
    input wire logic motion_irq_pin,
    input wire logic tap_irq_pin,
    input wire logic sleep_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // read strobes aimed at the two source registers and at the seven bit settings
    logic rd_msrc;
    logic rd_tsrc;
    logic rd_top0;
    assign rd_msrc = reg_rd && reg_addr == 8'h31;
    assign rd_tsrc = reg_rd && reg_addr == 8'h39;
    assign rd_top0 = reg_rd && (reg_addr == 8'h32 || reg_addr == 8'h33
        || reg_addr == 8'h3A || reg_addr == 8'h3E);
    property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read strobe got no answer");
    property p_rdata_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");
    property p_msrc_top; rd_msrc |=> reg_rdata[7] == 1'b0; endproperty
    a_msrc_top: assert property (p_msrc_top)
        else $error("motion source top bit not zero");
    property p_top_zero; rd_top0 |=> !reg_rdata[7]; endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("seven bit field read back a top bit");
    property p_mclear; rd_msrc && !sample_tick |=> !motion_irq_pin;
    endproperty
    a_mclear: assert property (p_mclear)
        else $error("motion pin not cleared by source read");
    property p_tclear;
        rd_tsrc && !sample_tick && !$past(sample_tick)
            && !$past(sample_tick, 2) |=> !tap_irq_pin;
    endproperty
    a_tclear: assert property (p_tclear)
        else $error("tap pin not cleared by source read");
    property p_mhold; motion_irq_pin && !rd_msrc |=> motion_irq_pin;
    endproperty
    a_mhold: assert property (p_mhold)
        else $error("motion pin dropped without a read");
    property p_thold; tap_irq_pin && !rd_tsrc |=> tap_irq_pin; endproperty
    a_thold: assert property (p_thold)
        else $error("tap pin dropped without a read");
    property p_mrise; $rose(motion_irq_pin) |-> $past(sample_tick); endproperty
    a_mrise: assert property (p_mrise)
        else $error("motion pin rose without a sample");
    property p_rst_quiet;
        $fell(sys_rst) |-> !motion_irq_pin && !tap_irq_pin && !sleep_state;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    // main scenarios reached
    c_mread: cover property (rd_msrc && motion_irq_pin);
    c_tap: cover property ($rose(tap_irq_pin));
    c_sleep: cover property ($rose(sleep_state));
endmodule
`default_nettype wire

// file: verif/tb_aecd_core.sv
// self-checking bench for the accelerometer event and tap block
`timescale 1ns/100ps
`default_nettype none
bind aecd_core aecd_core_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_tick(sample_tick),
    .motion_irq_pin(motion_irq_pin), .tap_irq_pin(tap_irq_pin),
    .sleep_state(sleep_state));
module tb_aecd_core;
    import aecd_pkg::*;
    logic ref_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, sample_tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] axis_irq_en;
    logic combine_and_select, orientation_select, latch_sel;
    logic motion_irq_pin, tap_irq_pin, sleep_state;
    aecd_accel_t accel;
    int error_cnt, n_tests;
    int cyc = 0;
    aecd_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sample_tick(sample_tick), .accel(accel),
        .axis_irq_en(axis_irq_en), .combine_and_select(combine_and_select),
        .orientation_select(orientation_select), .latch_sel(latch_sel),
        .motion_irq_pin(motion_irq_pin), .tap_irq_pin(tap_irq_pin),
        .sleep_state(sleep_state));
    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read one register and compare the answer
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask
    // n samples of x and y, then let the results settle
    task automatic ticks(input logic [15:0] xv, input logic [15:0] yv,
        input int n);
        repeat (n) begin
            @(posedge ref_clk);
            sample_tick <= 1'b1;
            accel.x <= xv;
            accel.y <= yv;
            @(posedge ref_clk);
            sample_tick <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic test_regs();
        logic [7:0] offs [12] = '{8'h31, 8'h32, 8'h33, 8'h38, 8'h39, 8'h3A,
            8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h30};
        logic [7:0] msk [12] = '{8'h00, 8'h7F, 8'h7F, 8'h3F, 8'h00, 8'h7F,
            8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h00};
        logic [7:0] wd;
        for (int i = 0; i < 12; i++) begin
            rd(offs[i], 8'h00);
            // the host keeps the top bit of both motion settings at zero
            wd = (offs[i] inside {8'h32, 8'h33}) ? 8'h7F : 8'hFF;
            wr(offs[i], wd);
            rd(offs[i], msk[i]);
            wr(offs[i], 8'h00);
        end
        $display("register test done");
    endtask
    task automatic test_motion();
        latch_sel <= 1'b1;
        axis_irq_en <= 6'h02;
        wr(8'h32, 8'h10);
        wr(8'h33, 8'h02);
        ticks(16'h2000, 16'h2000, 2);
        chk({7'h00, motion_irq_pin}, 8'h00);
        ticks(16'h2000, 16'h2000, 1);
        chk({7'h00, motion_irq_pin}, 8'h01);
        rd(8'h31, 8'h42);
        chk({7'h00, motion_irq_pin}, 8'h00);
        ticks(16'h0000, 16'h0000, 1);
        rd(8'h31, 8'h00);
        wr(8'h33, 8'h00);
        combine_and_select <= 1'b1;
        axis_irq_en <= 6'h0A;
        ticks(16'h2000, 16'h0000, 1);
        chk({7'h00, motion_irq_pin}, 8'h00);
        ticks(16'h2000, 16'h2000, 1);
        chk({7'h00, motion_irq_pin}, 8'h01);
        rd(8'h31, 8'h4A);
        combine_and_select <= 1'b0;
        orientation_select <= 1'b1;
        axis_irq_en <= 6'h02;
        ticks(16'h0000, 16'h0000, 1);
        ticks(16'h2000, 16'h0000, 1);
        chk({7'h00, motion_irq_pin}, 8'h01);
        rd(8'h31, 8'h42);
        ticks(16'h2000, 16'h0000, 1);
        chk({7'h00, motion_irq_pin}, 8'h00);
        combine_and_select <= 1'b1;
        ticks(16'h2000, 16'h0000, 1);
        chk({7'h00, motion_irq_pin}, 8'h01);
        axis_irq_en <= 6'h00;
        ticks(16'h0000, 16'h0000, 1);
        // latched flags stay until read, then refresh to zero
        rd(8'h31, 8'h42);
        rd(8'h31, 8'h00);
        // unlatched flags follow each sample
        latch_sel <= 1'b0;
        combine_and_select <= 1'b0;
        orientation_select <= 1'b0;
        axis_irq_en <= 6'h02;
        ticks(16'h2000, 16'h0000, 1);
        rd(8'h31, 8'h42);
        ticks(16'h0000, 16'h0000, 1);
        rd(8'h31, 8'h00);
        axis_irq_en <= 6'h00;
        $display("motion test done");
    endtask
    task automatic test_tap();
        wr(8'h3A, 8'h10);
        wr(8'h3B, 8'h03);
        wr(8'h38, 8'h01);
        ticks(16'hE000, 16'h0000, 5);
        ticks(16'h0000, 16'h0000, 1);
        chk({7'h00, tap_irq_pin}, 8'h00);
        ticks(16'hE000, 16'h0000, 4);
        ticks(16'h0000, 16'h0000, 1);
        chk({7'h00, tap_irq_pin}, 8'h01);
        rd(8'h39, 8'h59);
        chk({7'h00, tap_irq_pin}, 8'h00);
        rd(8'h39, 8'h19);
        wr(8'h38, 8'h02);
        wr(8'h3C, 8'h02);
        wr(8'h3D, 8'h08);
        ticks(16'h2000, 16'h0000, 1);
        ticks(16'h0000, 16'h0000, 1);
        chk({7'h00, tap_irq_pin}, 8'h00);
        ticks(16'h0000, 16'h0000, 3);
        ticks(16'h2000, 16'h0000, 1);
        ticks(16'h0000, 16'h0000, 1);
        chk({7'h00, tap_irq_pin}, 8'h01);
        rd(8'h39, 8'h61);
        wr(8'h38, 8'h00);
        $display("tap test done");
    endtask
    task automatic test_wake();
        wr(8'h3E, 8'h01);
        wr(8'h3F, 8'h00);
        ticks(16'h0020, 16'h0000, 1);
        chk({7'h00, sleep_state}, 8'h00);
        ticks(16'h0010, 16'h0000, 7);
        chk({7'h00, sleep_state}, 8'h00);
        ticks(16'h0010, 16'h0000, 1);
        chk({7'h00, sleep_state}, 8'h01);
        ticks(16'h0020, 16'h0000, 1);
        chk({7'h00, sleep_state}, 8'h00);
        $display("wake test done");
    endtask
    // main sequence
    initial begin
        error_cnt = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sample_tick = 1'b0;
        accel = '0;
        axis_irq_en = 6'h00;
        combine_and_select = 1'b0;
        orientation_select = 1'b0;
        latch_sel = 1'b0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        test_regs();
        test_motion();
        test_tap();
        test_wake();
        report_and_stop();
    end
endmodule
`default_nettype wire
